// File: src/osp_option_policy.sv
// Option switch bank decoder and buffer policy with AXI4-Lite registers
//
// Notes on behaviour
// RQ1 - Closed switch reads 0, open reads 1
// RQ2 - Ten switch inputs, numbered one to ten
// RQ3 - Switches 2,1 select 0/5/10/15 write retries
// RQ4 - Switches 4,3 select 0/5/10/15 read retries
// RQ5 - Enabled: sync after two consecutive tape marks
// RQ6 - Disabled: sync after a single tape mark
// RQ7 - Early end enabled: one record, no early status
// RQ8 - Early end disabled: at most four records
// RQ9 - Over four at warning: drain to four
// RQ10 - Actual end forces one-record policy always
// RQ11 - Reset default mode from switch 8
// RQ12 - Switch 9 formatter address, industry interface only
// RQ13 - Switches 7 and 10 have no effect
// RQ14 - Switches held from power-up or panel reset
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module osp_option_policy
    import osp_pkg::*;
#(
    parameter int REC_CNT_W = 8,
    parameter int SYNC_CNT_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [SW_COUNT:1] optSwitch,
    input wire logic frontPanelReset,
    input wire logic industryInterface,
    input wire logic tapeMarkRead,
    input wire logic tapeMarkWritten,
    input wire logic dataRecord,
    input wire logic earlyTapeEndWarning,
    input wire logic tapeEndReached,
    input wire logic tapeEndClear,
    input wire logic [REC_CNT_W-1:0] recordsBuffered,
    output osp_policy_type policy,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [SW_COUNT+1:0] pinSync;
    logic [SW_COUNT:1] switchNow;
    logic industryNow;
    logic panelNow;
    logic panelLast_reg;
    logic panelRise;

    // Every switch is an independent pin, bit n is switch n
    osp_sync #(
        .WIDTH(SW_COUNT + 2)
    ) pinSyncInst (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .asyncIn({industryInterface, frontPanelReset, optSwitch}), // RQ2
        .syncOut(pinSync)
    );

    // Split the synchronised pin group
    assign switchNow = pinSync[SW_COUNT-1:0];
    assign panelNow = pinSync[SW_COUNT];
    assign industryNow = pinSync[SW_COUNT+1];

    // Panel reset acts on its rising edge only
    always_ff @(posedge clk) begin
        if (reset) begin
            panelLast_reg <= 1'b0;
        end else if (ce) begin
            panelLast_reg <= panelNow;
        end
    end

    assign panelRise = panelNow && !panelLast_reg;

    // ****************************************
    // Switch sampling
    // ****************************************
    logic [1:0] startWait_reg;
    logic resampleReq;
    logic sampleNow;
    logic [SW_COUNT:1] heldSwitch_reg;

    // Wait for the synchroniser to fill before the power-up sample
    always_ff @(posedge clk) begin
        if (reset) begin
            startWait_reg <= START_WAIT;
        end else if (ce && startWait_reg != 2'h0) begin
            startWait_reg <= startWait_reg - 2'h1;
        end
    end

    assign sampleNow = ce && ((startWait_reg == 2'h1) || panelRise || resampleReq);

    // Switches are read at power-up, panel reset or resample and held; moving one in between does nothing
    always_ff @(posedge clk) begin
        if (reset) begin
            heldSwitch_reg <= SW_RESET;
        end else if (sampleNow) begin
            heldSwitch_reg <= switchNow; // RQ14
        end
    end

    // ****************************************
    // Field decode
    // ****************************************
    logic [3:0] writeRetry;
    logic [3:0] readRetry;
    logic twoMarkSync;
    logic earlyOneRecord;
    logic formatterAddr;

    // Code times five gives 0, 5, 10 or 15
    function automatic logic [3:0] retry_limit(input logic [1:0] code);
        return {2'h0, code} * RETRY_STEP;
    endfunction

    // Open switch (1) enables its option, closed (0) disables it
    assign writeRetry = retry_limit({heldSwitch_reg[SW_WR_RETRY_HI],
                                     heldSwitch_reg[SW_WR_RETRY_LO]}); // RQ3
    assign readRetry = retry_limit({heldSwitch_reg[SW_RD_RETRY_HI],
                                    heldSwitch_reg[SW_RD_RETRY_LO]}); // RQ4
    assign twoMarkSync = heldSwitch_reg[SW_MARK_SYNC] == OPT_ENABLED; // RQ1
    assign earlyOneRecord = heldSwitch_reg[SW_EARLY_END] == OPT_ENABLED; // RQ1
    // Proprietary interface forces address 0; spare bits 7 and 10 unread
    assign formatterAddr = industryNow && heldSwitch_reg[SW_FMT_ADDR]; // RQ12 RQ13

    // ****************************************
    // Tape mark buffer synchronisation
    // ****************************************
    logic markSeen;
    logic markRun_reg;
    logic syncFire;
    logic [SYNC_CNT_W-1:0] syncCount_reg;

    // Read and written marks count alike; a data record breaks the run
    assign markSeen = tapeMarkRead || tapeMarkWritten;
    assign syncFire = ce && markSeen && (!twoMarkSync || markRun_reg); // RQ5 RQ6

    // Remember one pending mark only when two are needed
    always_ff @(posedge clk) begin
        if (reset) begin
            markRun_reg <= 1'b0;
        end else if (ce) begin
            if (markSeen) begin
                markRun_reg <= twoMarkSync && !markRun_reg; // RQ5
            end else if (dataRecord || sampleNow) begin
                markRun_reg <= 1'b0;
            end
        end
    end

    // Count of syncs for software, wraps silently
    always_ff @(posedge clk) begin
        if (reset) begin
            syncCount_reg <= '0;
        end else if (syncFire) begin
            syncCount_reg <= syncCount_reg + 1'b1;
        end
    end

    // ****************************************
    // End of tape record policy
    // ****************************************
    logic tapeEnd_reg;
    logic singleRecord;
    logic fourLimit;
    logic acceptNext;
    logic drainNext;

    // Actual end latches; a new arrival wins over a clear
    always_ff @(posedge clk) begin
        if (reset) begin
            tapeEnd_reg <= 1'b0;
        end else if (ce) begin
            if (tapeEndReached) begin
                tapeEnd_reg <= 1'b1; // RQ10
            end else if (tapeEndClear || sampleNow) begin
                tapeEnd_reg <= 1'b0;
            end
        end
    end

    // Actual end overrides the switch; warning alone obeys it
    assign singleRecord = tapeEnd_reg
                          || (earlyTapeEndWarning && earlyOneRecord); // RQ7 RQ10
    assign fourLimit = earlyTapeEndWarning && !earlyOneRecord && !tapeEnd_reg; // RQ8

    // Admit a record only if the count after it stays within the limit
    always_comb begin
        if (singleRecord) begin
            acceptNext = recordsBuffered == '0; // RQ7
        end else if (fourLimit) begin
            acceptNext = recordsBuffered < REC_CNT_W'(EARLY_RECORD_LIMIT); // RQ8
        end else begin
            acceptNext = 1'b1;
        end
    end

    // Drain request stays up until four or fewer remain
    assign drainNext = fourLimit
                       && recordsBuffered > REC_CNT_W'(EARLY_RECORD_LIMIT); // RQ9

    // ****************************************
    // Operating mode
    // ****************************************
    logic longMode_reg;
    logic writeFire;
    logic ctrlWrite;
    logic [31:0] wData_reg;

    // Reset default from switch 8, software may change it later
    always_ff @(posedge clk) begin
        if (reset) begin
            longMode_reg <= 1'b0;
        end else if (sampleNow) begin
            longMode_reg <= switchNow[SW_LONG_RECORD] == OPT_ENABLED; // RQ11
        end else if (ctrlWrite) begin
            longMode_reg <= wData_reg[CTRL_MODE_BIT];
        end
    end

    // ****************************************
    // Policy outputs
    // ****************************************
    // Registered so the buffer manager sees glitch-free levels
    always_ff @(posedge clk) begin
        if (reset) begin
            policy <= '0;
        end else if (ce) begin
            policy.writeRetryLimit <= writeRetry;
            policy.readRetryLimit <= readRetry;
            policy.twoMarkSync <= twoMarkSync;
            policy.longRecordMode <= longMode_reg;
            policy.formatterAddress <= formatterAddr;
            policy.acceptWrite <= acceptNext;
            policy.earlyStatusEnable <= !singleRecord; // RQ7 RQ10
            policy.drainRequest <= drainNext;
            policy.bufferSync <= syncFire;
        end
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    logic awHeld_reg;
    logic [AXI_ADDR_W-1:0] awAddr_reg;
    logic wHeld_reg;
    logic [3:0] wStrb_reg;
    logic writeMapped;

    // Ready drops while frozen so no item is taken and lost
    assign s_axi_awready = ce && !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready = ce && !wHeld_reg && !s_axi_bvalid;
    assign writeFire = ce && awHeld_reg && wHeld_reg;
    assign ctrlWrite = writeFire && awAddr_reg == ADDR_CTRL && wStrb_reg[0];
    assign resampleReq = ctrlWrite && wData_reg[CTRL_RESAMPLE_BIT];
    assign writeMapped = awAddr_reg == ADDR_CTRL || awAddr_reg == ADDR_SWITCH
                         || awAddr_reg == ADDR_POLICY || awAddr_reg == ADDR_SYNCCNT;

    // Address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (reset) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wHeld_reg <= 1'b0;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= {s_axi_awaddr[AXI_ADDR_W-1:2], 2'h0};
            end else if (writeFire) begin
                awHeld_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end else if (writeFire) begin
                wHeld_reg <= 1'b0;
            end
        end
    end

    // Response once both halves are in; read-only words accept and ignore
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (writeFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    logic [AXI_ADDR_W-1:0] readAddr;
    logic [31:0] readWord;
    logic readMapped;

    assign s_axi_arready = ce && !s_axi_rvalid;
    assign readAddr = {s_axi_araddr[AXI_ADDR_W-1:2], 2'h0};

    // Read mux; spare switches always read as zero
    always_comb begin
        readWord = 32'h0000_0000;
        readMapped = 1'b1;
        case (readAddr)
            ADDR_CTRL: begin
                readWord[CTRL_MODE_BIT] = longMode_reg;
            end
            ADDR_SWITCH: begin
                readWord[SW_COUNT-1:0] = heldSwitch_reg & ~SW_SPARE_MASK; // RQ13
            end
            ADDR_POLICY: begin
                readWord[POL_WR_RETRY +: 4] = writeRetry;
                readWord[POL_RD_RETRY +: 4] = readRetry;
                readWord[POL_TWO_MARK] = twoMarkSync;
                readWord[POL_FMT_ADDR] = formatterAddr;
                readWord[POL_LONG_MODE] = longMode_reg;
                readWord[POL_TAPE_END] = tapeEnd_reg;
                readWord[POL_SINGLE] = singleRecord;
                readWord[POL_FOUR] = fourLimit;
                readWord[POL_DRAIN] = drainNext;
            end
            ADDR_SYNCCNT: begin
                readWord[SYNC_CNT_W-1:0] = syncCount_reg;
            end
            default: begin
                readMapped = 1'b0;
            end
        endcase
    end

    // One cycle from address to data
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readWord;
                s_axi_rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// File: src/osp_pkg.sv
// Constants and types for the option switch buffer policy block
package osp_pkg;

    // ****************************************
    // Switch bank layout
    // ****************************************
    localparam int SW_COUNT = 10;
    localparam int SYNC_STAGES = 2;
    localparam int SW_WR_RETRY_LO = 1;
    localparam int SW_WR_RETRY_HI = 2;
    localparam int SW_RD_RETRY_LO = 3;
    localparam int SW_RD_RETRY_HI = 4;
    localparam int SW_MARK_SYNC = 5;
    localparam int SW_EARLY_END = 6;
    localparam int SW_LONG_RECORD = 8;
    localparam int SW_FMT_ADDR = 9;
    // Switches 7 and 10 are spares, masked on readback
    localparam logic [SW_COUNT-1:0] SW_SPARE_MASK = 10'h240;
    localparam logic OPT_ENABLED = 1'b1;
    localparam logic [SW_COUNT-1:0] SW_RESET = 10'h000;

    // ****************************************
    // Policy figures
    // ****************************************
    localparam logic [3:0] RETRY_STEP = 4'h5;
    localparam int EARLY_RECORD_LIMIT = 4;
    localparam logic [1:0] START_WAIT = 2'h3;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int AXI_ADDR_W = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SWITCH = 4'h4;
    localparam logic [3:0] ADDR_POLICY = 4'h8;
    localparam logic [3:0] ADDR_SYNCCNT = 4'hc;
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_RESAMPLE_BIT = 1;
    localparam int POL_WR_RETRY = 0;
    localparam int POL_RD_RETRY = 4;
    localparam int POL_TWO_MARK = 8;
    localparam int POL_FMT_ADDR = 9;
    localparam int POL_LONG_MODE = 10;
    localparam int POL_TAPE_END = 11;
    localparam int POL_SINGLE = 12;
    localparam int POL_FOUR = 13;
    localparam int POL_DRAIN = 14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded policy handed to the cache processor and buffer manager
    typedef struct packed {
        logic [3:0] writeRetryLimit;
        logic [3:0] readRetryLimit;
        logic twoMarkSync;
        logic longRecordMode;
        logic formatterAddress;
        logic acceptWrite;
        logic earlyStatusEnable;
        logic drainRequest;
        logic bufferSync;
    } osp_policy_type;

endpackage

// File: src/osp_sync.sv
// Two-stage synchroniser for pins entering the clock domain
`timescale 1ns/1ns
module osp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else if (ce) begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule

// File: test/osp_option_policy_props.sv
// Port checker for the option policy block, bound to its top module
`timescale 1ns/1ns
module osp_option_policy_props
    import osp_pkg::*;
#(
    parameter int REC_CNT_W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic tapeMarkRead,
    input wire logic tapeMarkWritten,
    input wire logic tapeEndReached,
    input wire logic [REC_CNT_W-1:0] recordsBuffered,
    input wire osp_policy_type policy,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // A frozen clock enable stalls everything, so checks rest with it
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !ce);

    // Handshake and mark events
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence oneMarkHit;
        !policy.twoMarkSync && (tapeMarkRead || tapeMarkWritten);
    endsequence

    a_write_answer: assert property (wrTake |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (rdTake |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_one_mark: assert property (oneMarkHit |=> policy.bufferSync)
        else $error("single mark gave no sync");
    a_sync_cause: assert property (policy.bufferSync |-> $past(tapeMarkRead) || $past(tapeMarkWritten))
        else $error("sync without a mark");
    a_tape_end: assert property (tapeEndReached |-> ##[1:2] !policy.earlyStatusEnable)
        else $error("early status after tape end");
    a_drain_cause: assert property (policy.drainRequest |-> $past(recordsBuffered) > 4)
        else $error("drain with four or fewer records");
    a_retry_steps: assert property (policy.writeRetryLimit inside {4'h0, 4'h5, 4'ha, 4'hf}
        && policy.readRetryLimit inside {4'h0, 4'h5, 4'ha, 4'hf})
        else $error("retry limit off the step");
endmodule

bind osp_option_policy osp_option_policy_props #(.REC_CNT_W(REC_CNT_W)) uProps (.clk(clk),
    .reset(reset), .ce(ce), .tapeMarkRead(tapeMarkRead), .tapeMarkWritten(tapeMarkWritten),
    .tapeEndReached(tapeEndReached), .recordsBuffered(recordsBuffered), .policy(policy),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid));

// File: test/osp_buffer_model.sv
// Buffer occupancy model standing in for the buffer manager
`timescale 1ns/1ns
module osp_buffer_model
    import osp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic loadRec,
    input wire logic [7:0] loadVal,
    input wire osp_policy_type policy,
    output logic [7:0] recordsBuffered
);
    // Retires one record a cycle while asked; lag may leave it below four
    always_ff @(posedge clk) begin
        if (reset) begin
            recordsBuffered <= 8'h00;
        end else if (loadRec) begin
            recordsBuffered <= loadVal;
        end else if (policy.drainRequest && recordsBuffered != 8'h00) begin
            recordsBuffered <= recordsBuffered - 8'h01;
        end
    end
endmodule

// File: test/osp_option_policy_bench.sv
// Self-checking bench for the option policy block
`timescale 1ns/1ns
module osp_option_policy_bench
    import osp_pkg::*;
;
    logic clk = 1'h0, reset = 1'h1, ce = 1'h1, frontPanelReset = 1'h0, industryInterface = 1'h1;
    logic tapeMarkRead = 1'h0, tapeMarkWritten = 1'h0, dataRecord = 1'h0, loadRec = 1'h0;
    logic earlyTapeEndWarning = 1'h0, tapeEndReached = 1'h0, tapeEndClear = 1'h0;
    logic [SW_COUNT:1] optSwitch = 10'h080;
    logic [7:0] recordsBuffered, loadVal = 8'h00;
    osp_policy_type policy;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int nFail = 0, samplesChecked = 0, cyc = 0;

    osp_option_policy dut_u (.clk(clk), .reset(reset), .ce(ce), .optSwitch(optSwitch),
        .frontPanelReset(frontPanelReset), .industryInterface(industryInterface),
        .tapeMarkRead(tapeMarkRead), .tapeMarkWritten(tapeMarkWritten),
        .dataRecord(dataRecord), .earlyTapeEndWarning(earlyTapeEndWarning),
        .tapeEndReached(tapeEndReached), .tapeEndClear(tapeEndClear),
        .recordsBuffered(recordsBuffered), .policy(policy), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    osp_buffer_model model_u (.clk(clk), .reset(reset), .loadRec(loadRec),
        .loadVal(loadVal), .policy(policy), .recordsBuffered(recordsBuffered));

    // ****************************************
    // Clock, hang guard and helpers
    // ****************************************
    always #2 clk = ~clk;

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            nFail++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Switches settle through the synchroniser before the panel reset rises
    task automatic samp(input logic [SW_COUNT:1] v);
        @(posedge clk);
        optSwitch <= v;
        tick(4);
        frontPanelReset <= 1'h1;
        tick(4);
        frontPanelReset <= 1'h0;
        tick(6);
    endtask

    // Both channels offered together; each dropped at the edge it is taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic ga, gw, gb;
        gb = 1'h0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!gb) begin
            @(negedge clk);
            ga = s_axi_awvalid && s_axi_awready;
            gw = s_axi_wvalid && s_axi_wready;
            gb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk);
            if (ga) s_axi_awvalid <= 1'h0;
            if (gw) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
    endtask

    task automatic axr(input logic [3:0] a);
        logic ga, gr;
        gr = 1'h0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!gr) begin
            @(negedge clk);
            ga = s_axi_arvalid && s_axi_arready;
            gr = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (ga) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
    endtask

    task automatic mark(input logic fromTape, input logic expSync);
        @(posedge clk);
        tapeMarkRead <= fromTape;
        tapeMarkWritten <= !fromTape;
        @(posedge clk);
        tapeMarkRead <= 1'h0;
        tapeMarkWritten <= 1'h0;
        #1 chk(policy.bufferSync, expSync);
    endtask

    task automatic load(input logic [7:0] v);
        @(posedge clk);
        loadVal <= v;
        loadRec <= 1'h1;
        @(posedge clk);
        loadRec <= 1'h0;
        tick(3);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Every retry code, with spares, mode and address bits moving around it
    task automatic t_decode();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            samp({c[0], c[1], c[0], c[1], 2'h0, c, ~c});
            chk(policy.writeRetryLimit, 5 * (3 - i));
            chk(policy.readRetryLimit, 5 * i);
            chk(policy.longRecordMode, c[0]);
            chk(policy.formatterAddress, c[1]);
            chk(policy.twoMarkSync, 0);
            axr(ADDR_SWITCH);
            chk(rd, {22'h0, optSwitch & ~SW_SPARE_MASK});
        end
        industryInterface <= 1'h0;
        tick(6);
        chk(policy.formatterAddress, 0);
        industryInterface <= 1'h1;
    endtask

    // Switch moves between samples are ignored until a resample
    task automatic t_hold();
        @(posedge clk);
        optSwitch <= 10'h3ff;
        tick(10);
        chk(policy.writeRetryLimit, 0);
        axw(ADDR_CTRL, 32'h2);
        tick(4);
        chk(policy.writeRetryLimit, 15);
        chk(policy.longRecordMode, 1);
        axw(ADDR_CTRL, 32'h0);
        tick(2);
        chk(policy.longRecordMode, 0);
        axr(4'h2);
        // Low address bits are dropped, so offset 2 answers as the control word
        chk(rs, RESP_OKAY);
        chk(rd, 32'h0);
        axw(ADDR_POLICY, 32'h0);
        chk(rs, RESP_OKAY);
        axr(ADDR_POLICY);
        chk(rd[8:0], 9'h1ff);
    endtask

    task automatic t_marks();
        mark(1'h1, 1'h0);
        mark(1'h0, 1'h1);
        mark(1'h1, 1'h0);
        @(posedge clk);
        dataRecord <= 1'h1;
        @(posedge clk);
        dataRecord <= 1'h0;
        mark(1'h1, 1'h0);
        mark(1'h1, 1'h1);
        samp(10'h3ef);
        mark(1'h1, 1'h1);
        mark(1'h0, 1'h1);
        // A mark while frozen must not sync
        tick(1);
        ce <= 1'h0;
        mark(1'h1, 1'h0);
        ce <= 1'h1;
        axr(ADDR_SYNCCNT);
        chk(rd, 32'h4);
    endtask

    task automatic t_early();
        @(posedge clk);
        earlyTapeEndWarning <= 1'h1;
        load(8'h01);
        chk({policy.acceptWrite, policy.earlyStatusEnable}, 0);
        load(8'h00);
        chk(policy.acceptWrite, 1);
        samp(10'h3cf);
        load(8'h03);
        chk(policy.acceptWrite, 1);
        load(8'h04);
        chk(policy.acceptWrite, 0);
        load(8'h06);
        tick(12);
        chk({recordsBuffered <= 8'h04, policy.drainRequest}, 2'h2);
        load(8'h01);
        @(posedge clk);
        tapeEndReached <= 1'h1;
        @(posedge clk);
        tapeEndReached <= 1'h0;
        tick(3);
        chk({policy.acceptWrite, policy.earlyStatusEnable}, 0);
        tapeEndClear <= 1'h1;
        earlyTapeEndWarning <= 1'h0;
        @(posedge clk);
        tapeEndClear <= 1'h0;
        tick(3);
        chk({policy.acceptWrite, policy.earlyStatusEnable}, 2'h3);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        tick(10);
        chk(policy.longRecordMode, 1);
        t_decode();
        t_hold();
        t_marks();
        t_early();
        conclude();
    end
endmodule
